// File: iom_process_map.sv
// Process-data register map of the master radio node, one block per module slot
`include "iom_defines.svh"

module iom_process_map
	import iom_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire iom_req_type req_in,
	output iom_resp_type resp_out,
	input wire iom_event_type event_in,
	input wire logic [6:0] out_slot_in,
	output logic [3:0][15:0] out_data_out,
	output logic out_stale_out
);

	iom_state_type state;
	iom_state_type next_state;

	logic [6:0] dec_slot;
	logic [3:0] dec_index;
	logic dec_holding;
	logic dec_ok;
	logic [7:0] dec_exc;

	// The map answers every request on its port with no node check; node number is fixed at build time, see R11
	iom_addr_decode u_decode
	(
		.func_in(req_in.func),
		.addr_in(req_in.addr),
		.slot_out(dec_slot),
		.index_out(dec_index),
		.holding_out(dec_holding),
		.ok_out(dec_ok),
		.exc_out(dec_exc)
	);

	// Channel words are the only process data of a block; reads and writes both ask this
	function automatic logic iom_is_channel(input logic [3:0] idx);
		iom_is_channel = (idx >= `IOM_IDX_CH_FIRST) && (idx <= `IOM_IDX_CH_LAST); // see R12
	endfunction : iom_is_channel

	// Word 0 packs the flag above the type; every bit not named stays zero
	function automatic logic [15:0] iom_kind_word(input iom_block_type blk);
		logic [15:0] word;
		word = 16'h0000; // see R2
		word[7:0] = blk.kind; // see R1
		word[`IOM_STALE_BIT] = blk.stale; // see R1
		iom_kind_word = word;
	endfunction : iom_kind_word

	function automatic logic [15:0] iom_read_word(input iom_block_type blk, input logic [3:0] idx);
		logic [15:0] word;
		logic [3:0] ch_pos;
		word = 16'h0000; // see R15
		ch_pos = idx - `IOM_IDX_CH_FIRST;
		if (idx == `IOM_IDX_KIND_STALE)
		begin
			word = iom_kind_word(blk);
		end
		else if (iom_is_channel(idx))
		begin
			word = blk.ch[ch_pos[1:0]]; // see R12
		end
		iom_read_word = word; // see R13
	endfunction : iom_read_word

	// One radio report applied to one block
	function automatic iom_block_type iom_apply_event(input iom_block_type blk,
		input iom_event_type evt);
		iom_block_type upd;
		upd = blk;
		if (evt.lost)
		begin
			// Output blocks ignore link loss: once written they stay current
			if (!blk.is_out)
			begin
				// Channel words are left alone so the last values stay readable
				upd.stale = 1'b1; // see R4 R5
			end
		end
		else if (evt.kind == `IOM_KIND_NONE)
		begin
			upd.kind = `IOM_KIND_NONE; // see R3
			upd.stale = 1'b1; // see R4
			upd.is_out = 1'b0;
		end
		else if (evt.is_out)
		begin
			// A block that was not an output yet waits for its first write
			if (!blk.is_out)
			begin
				upd.stale = 1'b1; // see R6
			end
			upd.kind = evt.kind;
			upd.is_out = 1'b1;
		end
		else
		begin
			upd.kind = evt.kind;
			upd.is_out = 1'b0;
			upd.ch = evt.ch; // see R5
			upd.stale = 1'b0;
		end
		iom_apply_event = upd;
	endfunction : iom_apply_event

	// One bus word written into one block; anything but an output channel is dropped
	function automatic iom_block_type iom_apply_write(input iom_block_type blk,
		input logic [3:0] idx, input logic [15:0] wdata);
		iom_block_type upd;
		logic [3:0] ch_pos;
		upd = blk;
		ch_pos = idx - `IOM_IDX_CH_FIRST;
		if (blk.is_out && blk.kind != `IOM_KIND_NONE && iom_is_channel(idx))
		begin
			upd.ch[ch_pos[1:0]] = wdata;
			// Only a report of an empty slot sets the flag again for an output block; until then it stays clear
			upd.stale = 1'b0; // see R7
		end
		iom_apply_write = upd; // see R15
	endfunction : iom_apply_write

	// An empty slot shows its type word in both areas so a poll finds it absent either way
	function automatic logic iom_area_match(input iom_block_type blk, input logic holding);
		iom_area_match = (blk.kind == `IOM_KIND_NONE) || (blk.is_out == holding); // see R10
	endfunction : iom_area_match

	iom_block_type cur_blk;
	iom_block_type evt_blk;
	logic is_write;
	logic area_ok;
	logic evt_take;

	always_comb
	begin
		next_state = state;
		cur_blk = state.blocks[dec_slot];
		is_write = (req_in.func == `IOM_FC_WRITE_MULTIPLE);
		area_ok = iom_area_match(cur_blk, dec_holding);

		// Slot numbers above the map are dropped rather than wrapped onto a live block
		evt_take = event_in.valid && (event_in.slot <= `IOM_SLOT_LAST);

		// Radio side first, so a bus write in the same cycle has the last word
		evt_blk = iom_apply_event(state.blocks[event_in.slot], event_in);
		if (evt_take)
		begin
			next_state.blocks[event_in.slot] = evt_blk;
		end

		next_state.resp = '0;
		if (req_in.valid)
		begin
			next_state.resp.valid = 1'b1;
			if (!dec_ok)
			begin
				next_state.resp.err = 1'b1;
				next_state.resp.exc = dec_exc;
			end
			else if (is_write)
			begin
				// Built on the updated block so the bus write wins over a same-cycle report
				cur_blk = iom_apply_write(next_state.blocks[dec_slot], dec_index, req_in.wdata);
				next_state.blocks[dec_slot] = cur_blk;
			end
			else if (area_ok)
			begin
				next_state.resp.rdata = iom_read_word(cur_blk, dec_index); // see R10
			end
		end

		// The radio side fetches one cycle late; a slot above the map reads undefined words
		next_state.out_data = state.blocks[out_slot_in].ch;
		next_state.out_stale = state.blocks[out_slot_in].stale;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < `IOM_SLOT_COUNT; i++)
			begin
				state.blocks[i].kind <= `IOM_KIND_NONE;
				state.blocks[i].stale <= `IOM_RESET_STALE; // see R6
				state.blocks[i].is_out <= 1'b0;
				state.blocks[i].ch <= '0;
			end
			state.resp <= '0;
			state.out_data <= '0;
			state.out_stale <= `IOM_RESET_STALE;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign resp_out = state.resp;
	assign out_data_out = state.out_data;
	assign out_stale_out = state.out_stale;

endmodule : iom_process_map

// File: iom_defines.svh
// Constants of the I/O module process-data register map
// Function
// R1: Word 0 of each block holds the stale flag in bit 8 and the module type in the low bits.
// R2: The module type sits in bits 7 to 0 and the other upper bits of word 0 read as zero.
// R3: An invalid or absent module shows type zero in word 0 of its block.
// R4: The stale flag is set to one while a block is no longer refreshed, e.g. after link loss.
// R5: A stale input block keeps its last received values and is not updated further.
// R6: An output block reads stale from start-up until the master writes its output data.
// R7: After output data is written the stale flag of that block stays zero for good. Here a report of an empty slot sets it to one again.
// R8: The master trusts input data only when the type is non-zero and the stale flag is zero.
// R9: Register number is area prefix, two-digit slot, then index 0 to 9, so slot 01 gives 30010.
// R10: Word 0 is read in the input area for input modules and the holding area for outputs.
// R11: The whole map lives in the master radio node 01 and serves a serial-bus master.
// R12: For a four-channel analog input block, indices 2 to 5 hold channels 1 to 4.
// R13: Index 1 and indices 6 to 9 of that block are reserved and hold no process data.
// R14: Bus addresses start at zero, numbers at one; code 04 picks 3xxxx, 03 and 16 pick 4xxxx.
// R15: Reserved registers read as zero and writes to them are ignored.
`ifndef IOM_DEFINES_SVH
`define IOM_DEFINES_SVH

`define IOM_RADIO_NODE_NUMBER 8'h01
`define IOM_FC_READ_HOLDING 8'h03
`define IOM_FC_READ_INPUT 8'h04
`define IOM_FC_WRITE_MULTIPLE 8'h10
`define IOM_EXC_ILLEGAL_FUNCTION 8'h01
`define IOM_EXC_ILLEGAL_ADDRESS 8'h02
`define IOM_SLOT_COUNT 100
`define IOM_SLOT_FIRST 7'h01
`define IOM_SLOT_LAST 7'h63
`define IOM_WORDS_PER_SLOT 17'h0000a
`define IOM_NUMBER_OFFSET 17'h00001
`define IOM_IDX_KIND_STALE 4'h0
`define IOM_IDX_CH_FIRST 4'h2
`define IOM_IDX_CH_LAST 4'h5
`define IOM_STALE_BIT 8
`define IOM_KIND_NONE 8'h00
`define IOM_RESET_STALE 1'b1

`endif

// File: iom_pkg.sv
// Types shared by the process-data register map
package iom_pkg;

	typedef struct packed
	{
		logic valid;
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] wdata;
	} iom_req_type;

	typedef struct packed
	{
		logic valid;
		logic err;
		logic [7:0] exc;
		logic [15:0] rdata;
	} iom_resp_type;

	typedef struct packed
	{
		logic valid;
		logic lost;
		logic [6:0] slot;
		logic [7:0] kind;
		logic is_out;
		logic [3:0][15:0] ch;
	} iom_event_type;

	typedef struct packed
	{
		logic [7:0] kind;
		logic stale;
		logic is_out;
		logic [3:0][15:0] ch;
	} iom_block_type;

	typedef struct packed
	{
		iom_block_type [99:0] blocks;
		iom_resp_type resp;
		logic [3:0][15:0] out_data;
		logic out_stale;
	} iom_state_type;

endpackage : iom_pkg

// File: iom_addr_decode.sv
// Splits a bus request into block slot, block index and area
`include "iom_defines.svh"

module iom_addr_decode
	import iom_pkg::*;
(
	input wire logic [7:0] func_in,
	input wire logic [15:0] addr_in,
	output logic [6:0] slot_out,
	output logic [3:0] index_out,
	output logic holding_out,
	output logic ok_out,
	output logic [7:0] exc_out
);

	function automatic logic [16:0] iom_number(input logic [15:0] addr);
		iom_number = {1'b0, addr} + `IOM_NUMBER_OFFSET; // see R14
	endfunction : iom_number

	logic [16:0] number;
	logic [16:0] slot_wide;
	logic [16:0] index_wide;
	logic func_ok;

	always_comb
	begin
		number = iom_number(addr_in);
		slot_wide = number / `IOM_WORDS_PER_SLOT; // see R9
		index_wide = number % `IOM_WORDS_PER_SLOT; // see R9
		slot_out = slot_wide[6:0];
		index_out = index_wide[3:0];
		holding_out = (func_in != `IOM_FC_READ_INPUT); // see R14
		func_ok = (func_in == `IOM_FC_READ_INPUT) || (func_in == `IOM_FC_READ_HOLDING)
			|| (func_in == `IOM_FC_WRITE_MULTIPLE);
		ok_out = 1'b0;
		exc_out = 8'h00;
		if (!func_ok)
		begin
			exc_out = `IOM_EXC_ILLEGAL_FUNCTION;
		end
		else if (slot_wide < 17'(`IOM_SLOT_FIRST) || slot_wide > 17'(`IOM_SLOT_LAST))
		begin
			exc_out = `IOM_EXC_ILLEGAL_ADDRESS;
		end
		else
		begin
			ok_out = 1'b1;
		end
	end

endmodule : iom_addr_decode

// File: iom_process_map_assertions.sv
// Port checks of the process-data register map
module iom_process_map_assertions
	import iom_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire iom_req_type req_in,
	input wire iom_resp_type resp_out,
	input wire iom_event_type event_in,
	input wire logic [6:0] out_slot_in,
	input wire logic out_stale_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_take;
		req_in.valid;
	endsequence
	chk_answer_late: assert property (s_take |=> resp_out.valid)
		else $error("answer missing");
	chk_bad_func: assert property (s_take ##0 !(req_in.func inside {8'h03, 8'h04, 8'h10})
		|=> resp_out.err && resp_out.exc == 8'h01) else $error("bad code taken");
	chk_slot_zero: assert property (s_take ##0 (req_in.func == 8'h04 && req_in.addr < 16'h0009)
		|=> resp_out.exc == 8'h02) else $error("slot zero taken");
	chk_rsvd_zero: assert property (s_take ##0 (req_in.addr % 10 inside {0, 5, 6, 7, 8})
		|=> resp_out.rdata == 16'h0000) else $error("reserved word not zero");
	chk_word0_upper: assert property (s_take ##0 (req_in.addr % 10 == 9)
		|=> resp_out.rdata[15:9] == 7'h00) else $error("type word upper bits set");
	chk_err_nodata: assert property (resp_out.err |-> resp_out.rdata == 16'h0000)
		else $error("data with error");
	chk_stale_start: assert property ($rose(rst_n_in) |-> out_stale_out)
		else $error("output block not stale at start");
	// Only an event may set the flag again, and the flag shows it two cycles after the event
	chk_stale_held: assert property (!out_stale_out && $stable(out_slot_in) && !event_in.valid
		&& !$past(event_in.valid) |=> !out_stale_out) else $error("stale flag came back");
endmodule : iom_process_map_assertions

bind iom_process_map iom_process_map_assertions i_chk (.ref_clk_in, .rst_n_in, .req_in,
	.resp_out, .event_in, .out_slot_in, .out_stale_out);

// File: iom_bus_master.sv
// Serial-bus master model issuing one word per request
module iom_bus_master
	import iom_pkg::*;
(
	input wire logic ref_clk_in,
	input wire iom_resp_type resp_in,
	output iom_req_type req_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial req_out = '0;
	// Zero-based address; the code picks the area, answer one edge later
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, w, output iom_resp_type r);
		@(posedge ref_clk_in);
		#1 req_out = '{1'b1, f, a, w};
		@(posedge ref_clk_in);
		#1 r = resp_in;
		req_out.valid = 1'b0;
	endtask : xfer
endmodule : iom_bus_master

// File: iom_process_map_test.sv
// Self-checking bench of the process-data register map
module iom_process_map_test;
	import iom_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	iom_req_type req_in;
	iom_resp_type resp_out;
	iom_event_type event_in = '0;
	logic [6:0] out_slot_in = 7'h02;
	logic [3:0][15:0] out_data_out;
	logic out_stale_out;
	iom_resp_type r;
	int fail_count = 0;
	int comparisons = 0;
	initial forever #5 ref_clk_in = ~ref_clk_in;
	iom_bus_master i_master (.ref_clk_in, .resp_in(resp_out), .req_out(req_in));
	iom_process_map i_dut (.ref_clk_in, .rst_n_in, .req_in, .resp_out, .event_in,
		.out_slot_in, .out_data_out, .out_stale_out);
	task automatic check(input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rd(input logic [7:0] f, input logic [15:0] a, exp);
		i_master.xfer(f, a, 16'h0000, r);
		check(r.rdata, exp);
	endtask : rd
	task automatic radio(input logic lost, input logic [6:0] s, input logic [7:0] k, o);
		@(posedge ref_clk_in);
		#1 event_in = '{1'b1, lost, s, k, o[0], {16'h4444, 16'h3333, 16'h2222, 16'h1111}};
		@(posedge ref_clk_in);
		#1 event_in.valid = 1'b0;
	endtask : radio
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (8) @(posedge ref_clk_in);
		#1 rst_n_in = 1'b1;
		rd(8'h04, 16'h0009, 16'h0100);
		check({15'h0000, out_stale_out}, 16'h0001);
		$display("reset test done");
		radio(1'b0, 7'h01, 8'h5a, 8'h00);
		rd(8'h04, 16'h0009, 16'h005a);
		for (int i = 0; i < 4; i++)
			rd(8'h04, 16'h000b + 16'(i), 16'h1111 * 16'(i + 1));
		rd(8'h04, 16'h000a, 16'h0000);
		rd(8'h03, 16'h0009, 16'h0000);
		radio(1'b1, 7'h01, 8'h5a, 8'h00);
		rd(8'h04, 16'h0009, 16'h015a);
		rd(8'h04, 16'h000b, 16'h1111);
		$display("input test done");
		radio(1'b0, 7'h02, 8'h6b, 8'h01);
		rd(8'h03, 16'h0013, 16'h016b);
		i_master.xfer(8'h10, 16'h0015, 16'hbeef, r);
		i_master.xfer(8'h10, 16'h0014, 16'h7777, r);
		rd(8'h03, 16'h0014, 16'h0000);
		radio(1'b1, 7'h02, 8'h6b, 8'h01);
		rd(8'h03, 16'h0013, 16'h006b);
		check(out_data_out[0], 16'hbeef);
		check({15'h0000, out_stale_out}, 16'h0000);
		$display("output test done");
		i_master.xfer(8'h05, 16'h0009, 16'h0000, r);
		check({7'h00, r.err, r.exc}, 16'h0101);
		i_master.xfer(8'h04, 16'h0003, 16'h0000, r);
		check({7'h00, r.err, r.exc}, 16'h0102);
		radio(1'b0, 7'h01, 8'h00, 8'h00);
		rd(8'h04, 16'h0009, 16'h0100);
		$display("refusal test done");
		report_and_stop();
	end
endmodule : iom_process_map_test
